// ---- common/rsb_pkg.sv ----
package rsb_pkg;

	localparam int ADDR_W = 18;

	// printed offsets are register indices; byte address is four times the index
	localparam logic [15:0] BREAK_STATUS_IDX = 16'hfe00;
	localparam logic [15:0] RESET_SOURCE_IDX = 16'hfe01;
	localparam logic [15:0] BREAK_FLAG_CTRL_IDX = 16'hfe03;
	localparam logic [15:0] IRQ_STATUS_IDX = 16'hfe04;
	localparam logic [15:0] IRQ_MASK_IDX = 16'hfe05;

	localparam logic [ADDR_W-1:0] BREAK_STATUS_ADDR = {BREAK_STATUS_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] RESET_SOURCE_ADDR = {RESET_SOURCE_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] BREAK_FLAG_CTRL_ADDR = {BREAK_FLAG_CTRL_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = {IRQ_STATUS_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'h0};

	// field positions
	localparam int BSR_WAIT_EXIT_BIT = 1;
	localparam int SRC_POWER_ON_BIT = 7;
	localparam int SRC_EXT_PIN_BIT = 6;
	localparam int SRC_WATCHDOG_BIT = 5;
	localparam int SRC_BAD_OPCODE_BIT = 4;
	localparam int SRC_BAD_FETCH_BIT = 3;
	localparam int SRC_MONITOR_BIT = 2;
	localparam int SRC_LOW_VOLTAGE_BIT = 1;
	localparam int BFC_CLEAR_EN_BIT = 7;
	localparam int IRQ_BREAK_EXIT_BIT = 0;
	localparam int IRQ_RESET_CAUSE_BIT = 1;
	localparam int IRQ_W = 2;

	// reset values
	localparam logic [7:0] RESET_SOURCE_RST = 8'h80;
	localparam logic BREAK_EXIT_RST = 1'b0;
	localparam logic CLEAR_EN_RST = 1'b0;
	localparam logic [IRQ_W-1:0] IRQ_STATUS_RST = 2'h0;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		WR_COLLECT = 2'h0,
		WR_APPLY = 2'h1,
		WR_RESP = 2'h3
	} rsb_wr_state_type;

	typedef enum logic {
		RD_IDLE = 1'b0,
		RD_RESP = 1'b1
	} rsb_rd_state_type;

endpackage

// ---- common/rsb_reg_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface rsb_reg_if;
	import rsb_pkg::*;
	logic wrEn;
	logic rdEn;
	logic [ADDR_W-1:0] addr;
	logic [7:0] wdata;
	logic wrByte;
	logic [7:0] rdata;
	logic hit;
	modport bus (output wrEn, output rdEn, output addr, output wdata, output wrByte,
		input rdata, input hit);
	modport regs (input wrEn, input rdEn, input addr, input wdata, input wrByte,
		output rdata, output hit);
endinterface
`default_nettype wire

// ---- rtl/rsb_axil_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsb_axil_slave
	import rsb_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset, high
	input wire logic [rsb_pkg::ADDR_W-1:0] awaddr, // write address
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // byte enables
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	output logic [1:0] bresp, // write response
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	input wire logic [rsb_pkg::ADDR_W-1:0] araddr, // read address
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	rsb_reg_if.bus rb // register strobe side
);
	rsb_wr_state_type wrState_r, wrState_nxt;
	rsb_rd_state_type rdState_r, rdState_nxt;
	logic awHave_r, awHave_nxt, wHave_r, wHave_nxt;
	logic [ADDR_W-1:0] awAddr_r, awAddr_nxt;
	logic [7:0] wByte_r, wByte_nxt;
	logic wLane_r, wLane_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [7:0] rByte_r, rByte_nxt;

	assign awready = (wrState_r == WR_COLLECT) && !awHave_r;
	assign wready = (wrState_r == WR_COLLECT) && !wHave_r;
	// a read may not share the strobe cycle of a write
	assign arready = (rdState_r == RD_IDLE) && (wrState_r != WR_APPLY);
	assign bvalid = (wrState_r == WR_RESP);
	assign rvalid = (rdState_r == RD_RESP);
	assign bresp = bresp_r;
	assign rresp = rresp_r;
	assign rdata = {24'h0, rByte_r};

	assign rb.wrEn = (wrState_r == WR_APPLY);
	assign rb.rdEn = arvalid && arready;
	assign rb.addr = (wrState_r == WR_APPLY) ? awAddr_r : araddr;
	assign rb.wdata = wByte_r;
	assign rb.wrByte = wLane_r;

	always_comb begin
		wrState_nxt = wrState_r;
		awHave_nxt = awHave_r;
		wHave_nxt = wHave_r;
		awAddr_nxt = awAddr_r;
		wByte_nxt = wByte_r;
		wLane_nxt = wLane_r;
		bresp_nxt = bresp_r;
		case (wrState_r)
			WR_COLLECT: begin
				if (awvalid && awready) begin
					awHave_nxt = 1'b1;
					awAddr_nxt = awaddr;
				end
				if (wvalid && wready) begin
					wHave_nxt = 1'b1;
					wByte_nxt = wdata[7:0];
					wLane_nxt = wstrb[0];
				end
				if (awHave_nxt && wHave_nxt) begin
					wrState_nxt = WR_APPLY;
				end
			end
			WR_APPLY: begin
				bresp_nxt = rb.hit ? RESP_OKAY : RESP_SLVERR;
				awHave_nxt = 1'b0;
				wHave_nxt = 1'b0;
				wrState_nxt = WR_RESP;
			end
			WR_RESP: begin
				if (bready) begin
					wrState_nxt = WR_COLLECT;
				end
			end
			default: begin
				wrState_nxt = WR_COLLECT;
			end
		endcase
	end

	always_comb begin
		rdState_nxt = rdState_r;
		rByte_nxt = rByte_r;
		rresp_nxt = rresp_r;
		case (rdState_r)
			RD_IDLE: begin
				if (rb.rdEn) begin
					rByte_nxt = rb.rdata;
					rresp_nxt = rb.hit ? RESP_OKAY : RESP_SLVERR;
					rdState_nxt = RD_RESP;
				end
			end
			RD_RESP: begin
				if (rready) begin
					rdState_nxt = RD_IDLE;
				end
			end
			default: begin
				rdState_nxt = RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wrState_r <= WR_COLLECT;
			rdState_r <= RD_IDLE;
			awHave_r <= 1'b0;
			wHave_r <= 1'b0;
			awAddr_r <= '0;
			wByte_r <= 8'h0;
			wLane_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rresp_r <= RESP_OKAY;
			rByte_r <= 8'h0;
		end else begin
			wrState_r <= wrState_nxt;
			rdState_r <= rdState_nxt;
			awHave_r <= awHave_nxt;
			wHave_r <= wHave_nxt;
			awAddr_r <= awAddr_nxt;
			wByte_r <= wByte_nxt;
			wLane_r <= wLane_nxt;
			bresp_r <= bresp_nxt;
			rresp_r <= rresp_nxt;
			rByte_r <= rByte_nxt;
		end
	end

endmodule // rsb_axil_slave
`default_nettype wire

// ---- rtl/rsb_system_integration.sv ----
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
//Contract
// - three registers: break status, reset source and break flag control at fixed places; the code also maps irq status and irq mask.
// - break status only matters in emulation; otherwise it merely stores its flag.
// - break flag sets when a break interrupt ends wait mode.
// - writing 0 to the break flag clears it; any reset clears it too.
// - reset source holds the cause flags; exclusive only if cleared before.
// - reading the reset source register clears all of its flags.
// - power-on reset sets the power-on flag and clears the others.
// - external reset pin sets the pin flag; power-on or read clears it.
// - watchdog timeout sets the watchdog flag; power-on or read clears it.
// - illegal opcode sets its flag; power-on or read clears it.
// - illegal address flag sets for opcode fetches only, never data accesses.
// - monitor flag sets on monitor entry with erased vector and interrupt pin high.
// - low-voltage inhibit sets its flag; power-on or read clears it.
// - in break state, status clears act only when the clear-enable bit is set.
module rsb_system_integration
	import rsb_pkg::*;
(
	input wire logic clk_sys, // 200 MHz bus clock
	input wire logic rst, // power-on reset, async, high
	input wire logic [rsb_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [rsb_pkg::ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic reset_pin_n, // external reset pin, asynchronous
	input wire logic watchdogTimeout, // watchdog reset pulse
	input wire logic badOpcodeReset, // illegal opcode reset pulse
	input wire logic badAddrReset, // illegal address reset pulse
	input wire logic badAddrFetch, // illegal access was an opcode fetch
	input wire logic monitorEntry, // monitor mode entry reset pulse
	input wire logic [7:0] vectorHiByte, // reset vector high byte
	input wire logic [7:0] vectorLoByte, // reset vector low byte
	input wire logic ext_interrupt_pin, // interrupt pin level, asynchronous
	input wire logic lowVoltageReset, // low-voltage inhibit reset pulse
	input wire logic breakWaitExit, // break interrupt ended wait mode, pulse
	input wire logic breakState, // cpu is in a break state
	output logic breakWaitExitFlag, // break flag, registered
	output logic irq // level interrupt
);
	rsb_reg_if rb();

	rsb_axil_slave u_slave (
		.clk_sys(clk_sys),
		.rst(rst),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.rb(rb.bus)
	);

	// pin synchronisers
	logic pinSync1_r, pinSync2_r, pinPrev_r;
	logic irqPinSync1_r, irqPinSync2_r;
	logic pinEvent;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pinSync1_r <= 1'b1;
			pinSync2_r <= 1'b1;
			pinPrev_r <= 1'b1;
			irqPinSync1_r <= 1'b0;
			irqPinSync2_r <= 1'b0;
		end else begin
			pinSync1_r <= reset_pin_n;
			pinSync2_r <= pinSync1_r;
			pinPrev_r <= pinSync2_r;
			irqPinSync1_r <= ext_interrupt_pin;
			irqPinSync2_r <= irqPinSync1_r;
		end
	end

	// one event per assertion of the pin, however long it is held
	assign pinEvent = pinPrev_r && !pinSync2_r;

	// decode
	logic selBreak, selSource, selCtrl, selIrqStat, selIrqMask;
	logic wrBreak, wrCtrl, wrIrqStat, wrIrqMask, rdSource;
	logic clearAllowed;

	assign selBreak = (rb.addr == BREAK_STATUS_ADDR);
	assign selSource = (rb.addr == RESET_SOURCE_ADDR);
	assign selCtrl = (rb.addr == BREAK_FLAG_CTRL_ADDR);
	assign selIrqStat = (rb.addr == IRQ_STATUS_ADDR);
	assign selIrqMask = (rb.addr == IRQ_MASK_ADDR);
	assign rb.hit = selBreak || selSource || selCtrl || selIrqStat || selIrqMask;

	// only lane 0 carries a register; other lanes are ignored
	assign wrBreak = rb.wrEn && rb.wrByte && selBreak;
	assign wrCtrl = rb.wrEn && rb.wrByte && selCtrl;
	assign wrIrqStat = rb.wrEn && rb.wrByte && selIrqStat;
	assign wrIrqMask = rb.wrEn && rb.wrByte && selIrqMask;
	assign rdSource = rb.rdEn && selSource;

	// register state
	logic [7:0] resetSrc_r, resetSrc_nxt;
	logic breakExit_r, breakExit_nxt;
	logic clearEn_r, clearEn_nxt;
	logic [IRQ_W-1:0] irqStatus_r, irqStatus_nxt;
	logic [IRQ_W-1:0] irqMask_r, irqMask_nxt;
	logic fetchEvent, monitorEvent, anyReset;

	// debuggers must be able to inspect flags without destroying them
	assign clearAllowed = !breakState || clearEn_r;

	// data-side illegal accesses reset the part but set no reset source flag
	assign fetchEvent = badAddrReset && badAddrFetch;
	assign monitorEvent = monitorEntry && irqPinSync2_r && (vectorHiByte == ERASED_BYTE)
		&& (vectorLoByte == ERASED_BYTE);
	assign anyReset = pinEvent || watchdogTimeout || badOpcodeReset || badAddrReset
		|| monitorEntry || lowVoltageReset;

	always_comb begin
		resetSrc_nxt = resetSrc_r;
		if (rdSource && clearAllowed) begin
			resetSrc_nxt = 8'h0;
		end
		// flags only accumulate; an earlier cause stays until a read
		if (pinEvent) begin
			resetSrc_nxt[SRC_EXT_PIN_BIT] = 1'b1;
		end
		if (watchdogTimeout) begin
			resetSrc_nxt[SRC_WATCHDOG_BIT] = 1'b1;
		end
		if (badOpcodeReset) begin
			resetSrc_nxt[SRC_BAD_OPCODE_BIT] = 1'b1;
		end
		if (fetchEvent) begin
			resetSrc_nxt[SRC_BAD_FETCH_BIT] = 1'b1;
		end
		if (monitorEvent) begin
			resetSrc_nxt[SRC_MONITOR_BIT] = 1'b1;
		end
		if (lowVoltageReset) begin
			resetSrc_nxt[SRC_LOW_VOLTAGE_BIT] = 1'b1;
		end
		resetSrc_nxt[0] = 1'b0;
	end

	always_comb begin
		breakExit_nxt = breakExit_r;
		if (wrBreak && !rb.wdata[BSR_WAIT_EXIT_BIT] && clearAllowed) begin
			breakExit_nxt = 1'b0;
		end
		if (breakWaitExit) begin
			breakExit_nxt = 1'b1;
		end
		if (anyReset) begin
			breakExit_nxt = 1'b0;
		end
	end

	always_comb begin
		clearEn_nxt = clearEn_r;
		if (wrCtrl) begin
			clearEn_nxt = rb.wdata[BFC_CLEAR_EN_BIT];
		end
	end

	always_comb begin
		irqStatus_nxt = irqStatus_r;
		irqMask_nxt = irqMask_r;
		if (wrIrqStat && clearAllowed) begin
			irqStatus_nxt = irqStatus_r & ~rb.wdata[IRQ_W-1:0];
		end
		if (breakWaitExit) begin
			irqStatus_nxt[IRQ_BREAK_EXIT_BIT] = 1'b1;
		end
		if (anyReset) begin
			irqStatus_nxt[IRQ_RESET_CAUSE_BIT] = 1'b1;
		end
		if (wrIrqMask) begin
			irqMask_nxt = rb.wdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			resetSrc_r <= RESET_SOURCE_RST;
			breakExit_r <= BREAK_EXIT_RST;
			clearEn_r <= CLEAR_EN_RST;
			irqStatus_r <= IRQ_STATUS_RST;
			irqMask_r <= IRQ_MASK_RST;
		end else begin
			resetSrc_r <= resetSrc_nxt;
			breakExit_r <= breakExit_nxt;
			clearEn_r <= clearEn_nxt;
			irqStatus_r <= irqStatus_nxt;
			irqMask_r <= irqMask_nxt;
		end
	end

	// read mux; unused bits return zero
	always_comb begin
		rb.rdata = 8'h0;
		if (selBreak) begin
			rb.rdata[BSR_WAIT_EXIT_BIT] = breakExit_r;
		end else if (selSource) begin
			rb.rdata = resetSrc_r;
		end else if (selCtrl) begin
			rb.rdata[BFC_CLEAR_EN_BIT] = clearEn_r;
		end else if (selIrqStat) begin
			rb.rdata[IRQ_W-1:0] = irqStatus_r;
		end else if (selIrqMask) begin
			rb.rdata[IRQ_W-1:0] = irqMask_r;
		end
	end

	assign breakWaitExitFlag = breakExit_r;
	assign irq = |(irqStatus_r & irqMask_r);

endmodule // rsb_system_integration
`default_nettype wire

// ---- verif/rsb_si_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsb_si_sva (
	input wire logic clk_sys, // clock
	input wire logic rst, // reset
	input wire logic s_axi_awvalid, // aw
	input wire logic s_axi_awready, // aw
	input wire logic s_axi_wvalid, // w
	input wire logic s_axi_wready, // w
	input wire logic s_axi_bvalid, // b
	input wire logic s_axi_bready, // b
	input wire logic s_axi_arvalid, // ar
	input wire logic s_axi_arready, // ar
	input wire logic [31:0] s_axi_rdata, // r
	input wire logic s_axi_rvalid, // r
	input wire logic s_axi_rready, // r
	input wire logic reset_pin_n, // pin
	input wire logic watchdogTimeout, // cause
	input wire logic badOpcodeReset, // cause
	input wire logic badAddrReset, // cause
	input wire logic monitorEntry, // cause
	input wire logic lowVoltageReset, // cause
	input wire logic breakWaitExit, // event
	input wire logic breakWaitExitFlag // flag
);
	logic [3:0] pinHist;
	logic causeEvt;
	// a pin event lands a few edges late, so the pin must be quiet that long
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) pinHist <= 4'hf;
		else pinHist <= {pinHist[2:0], reset_pin_n};
	end
	assign causeEvt = watchdogTimeout | badOpcodeReset | badAddrReset | monitorEntry
		| lowVoltageReset;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	a_resp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_flag_set: assert property (breakWaitExit && !causeEvt && (&pinHist) && reset_pin_n
		|=> breakWaitExitFlag) else $error("break flag not set");
	a_flag_rise: assert property ($rose(breakWaitExitFlag) |-> $past(breakWaitExit))
		else $error("break flag set without cause");
	a_cause_clear: assert property (causeEvt |=> !breakWaitExitFlag)
		else $error("break flag survived reset");
endmodule // rsb_si_sva
bind rsb_system_integration rsb_si_sva u_sva (.*);
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rsb_pkg::*;
	localparam logic [ADDR_W-1:0] UNMAPPED = 18'h3f808;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic [5:0] evt = '0;
	logic pinN = 1'b1;
	logic fetch = 1'b1;
	logic [7:0] vec = 8'hff;
	logic intPin = 1'b1;
	logic brk = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, flag, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] causeBit [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h02};
	int errorCnt = 0;
	int nCompared = 0;

	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end

	rsb_system_integration dut (
		.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.reset_pin_n(pinN), .watchdogTimeout(evt[0]), .badOpcodeReset(evt[1]),
		.badAddrReset(evt[2]), .badAddrFetch(fetch), .monitorEntry(evt[3]),
		.vectorHiByte(vec), .vectorLoByte(vec), .ext_interrupt_pin(intPin),
		.lowVoltageReset(evt[4]), .breakWaitExit(evt[5]), .breakState(brk),
		.breakWaitExitFlag(flag), .irq(irq)
	);

	task automatic tally_and_finish;
		if (errorCnt == 0 && nCompared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		nCompared++;
		if (s !== e) begin
			errorCnt++;
			$display("MISMATCH %0t seen %h exp %h", $time, s, e);
		end
	endtask

	task automatic stuck;
		errorCnt++;
		$display("MISMATCH %0t no bus answer", $time);
		tally_and_finish;
	endtask

	// each transfer ends one edge after its answer so no strobe is driven twice at once
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (n > 40) stuck;
		end while (!(bvalid && bready));
		chk({30'h0, bresp}, {30'h0, er});
		bready <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (arready) arvalid <= 1'b0;
			if (n > 40) stuck;
		end while (!(rvalid && rready));
		chk(rdata, {24'h0, d});
		chk({30'h0, rresp}, {30'h0, er});
		rready <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic pulse(input int i);
		evt[i] <= 1'b1;
		@(posedge clk_sys);
		evt[i] <= 1'b0;
		@(posedge clk_sys);
	endtask

	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk({31'h0, flag}, 32'h0);
		rd(RESET_SOURCE_ADDR, 8'h80, RESP_OKAY);
		rd(RESET_SOURCE_ADDR, 8'h00, RESP_OKAY);
		rd(BREAK_STATUS_ADDR, 8'h00, RESP_OKAY);
		rd(BREAK_FLAG_CTRL_ADDR, 8'h00, RESP_OKAY);
		rd(UNMAPPED, 8'h00, RESP_SLVERR);
		wr(UNMAPPED, 8'hff, 4'h1, RESP_SLVERR);
		for (int i = 0; i < 5; i++) begin
			pulse(i);
			rd(RESET_SOURCE_ADDR, causeBit[i], RESP_OKAY);
			rd(RESET_SOURCE_ADDR, 8'h00, RESP_OKAY);
		end
		fetch <= 1'b0;
		pulse(2);
		rd(RESET_SOURCE_ADDR, 8'h00, RESP_OKAY);
		fetch <= 1'b1;
		vec <= 8'hfe;
		pulse(3);
		rd(RESET_SOURCE_ADDR, 8'h00, RESP_OKAY);
		vec <= 8'hff;
		intPin <= 1'b0;
		repeat (4) @(posedge clk_sys);
		pulse(3);
		rd(RESET_SOURCE_ADDR, 8'h00, RESP_OKAY);
		intPin <= 1'b1;
		pinN <= 1'b0;
		repeat (3) @(posedge clk_sys);
		pinN <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd(RESET_SOURCE_ADDR, 8'h40, RESP_OKAY);
		pulse(0);
		pulse(1);
		rd(RESET_SOURCE_ADDR, 8'h30, RESP_OKAY);
		pulse(5);
		chk({31'h0, flag}, 32'h1);
		rd(BREAK_STATUS_ADDR, 8'h02, RESP_OKAY);
		wr(BREAK_STATUS_ADDR, 8'h02, 4'h1, RESP_OKAY);
		rd(BREAK_STATUS_ADDR, 8'h02, RESP_OKAY);
		wr(BREAK_STATUS_ADDR, 8'h00, 4'h1, RESP_OKAY);
		rd(BREAK_STATUS_ADDR, 8'h00, RESP_OKAY);
		pulse(5);
		pulse(4);
		rd(BREAK_STATUS_ADDR, 8'h00, RESP_OKAY);
		rd(RESET_SOURCE_ADDR, 8'h02, RESP_OKAY);
		wr(BREAK_FLAG_CTRL_ADDR, 8'hff, 4'h0, RESP_OKAY);
		rd(BREAK_FLAG_CTRL_ADDR, 8'h00, RESP_OKAY);
		pulse(0);
		pulse(5);
		brk <= 1'b1;
		wr(BREAK_STATUS_ADDR, 8'h00, 4'h1, RESP_OKAY);
		rd(BREAK_STATUS_ADDR, 8'h02, RESP_OKAY);
		rd(RESET_SOURCE_ADDR, 8'h20, RESP_OKAY);
		rd(RESET_SOURCE_ADDR, 8'h20, RESP_OKAY);
		wr(BREAK_FLAG_CTRL_ADDR, 8'hff, 4'h1, RESP_OKAY);
		rd(BREAK_FLAG_CTRL_ADDR, 8'h80, RESP_OKAY);
		rd(RESET_SOURCE_ADDR, 8'h20, RESP_OKAY);
		rd(RESET_SOURCE_ADDR, 8'h00, RESP_OKAY);
		wr(BREAK_STATUS_ADDR, 8'h00, 4'h1, RESP_OKAY);
		rd(BREAK_STATUS_ADDR, 8'h00, RESP_OKAY);
		brk <= 1'b0;
		chk({31'h0, irq}, 32'h0);
		rd(IRQ_STATUS_ADDR, 8'h03, RESP_OKAY);
		wr(IRQ_MASK_ADDR, 8'h01, 4'h1, RESP_OKAY);
		chk({31'h0, irq}, 32'h1);
		wr(IRQ_STATUS_ADDR, 8'h01, 4'h1, RESP_OKAY);
		chk({31'h0, irq}, 32'h0);
		rd(IRQ_STATUS_ADDR, 8'h02, RESP_OKAY);
		pulse(5);
		chk({31'h0, irq}, 32'h1);
		wr(IRQ_MASK_ADDR, 8'h00, 4'h1, RESP_OKAY);
		chk({31'h0, irq}, 32'h0);
		wr(IRQ_STATUS_ADDR, 8'h03, 4'h1, RESP_OKAY);
		rd(IRQ_STATUS_ADDR, 8'h00, RESP_OKAY);
		tally_and_finish;
	end
endmodule // tb_top
`default_nettype wire
